// [src/atr_trim_bank.sv]
// Analog trim register bank reached over the die-to-die register port
`timescale 1ns/10ps
module atr_trim_bank
	import atr_pkg::*;
#(
	parameter int ADDR_W = atr_pkg::ATR_ADDR_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic bus_sel_i,
	input wire logic bus_wr_i,
	input wire logic [ADDR_W-1:0] bus_addr_i,
	input wire logic [atr_pkg::ATR_DATA_W-1:0] bus_wdata_i,
	output logic [atr_pkg::ATR_DATA_W-1:0] bus_rdata_o,
	output logic bus_ack_o,
	output logic bus_nonblock_o,
	output logic lin_slope_adjust_o,
	output logic [atr_pkg::ATR_CODE_W-1:0] wdog_clock_trim_code_o,
	output logic bandgap_slope_up_o,
	output logic bandgap_slope_down_o,
	output logic [atr_pkg::ATR_CODE_W-1:0] current_ref_trim_code_o,
	output logic [atr_pkg::ATR_CODE_W-1:0] sleep_ref_trim_code_o,
	output logic sleep_ref_trim_lock_o
);
	import atr_pkg::*;

	if (ADDR_W != ATR_ADDR_W) begin : g_chk
		$error("atr_trim_bank: ADDR_W must equal the global address width");
	end

	logic [ATR_DATA_W-1:0] lin_wdog_ff;
	logic [ATR_DATA_W-1:0] bg_iref_ff;
	logic [ATR_SLP_STORED_W-1:0] sleep_ff;
	logic [ATR_DATA_W-1:0] rdata_ff;
	logic ack_ff;
	logic nonblock_ff;
	logic [ATR_DATA_W-1:0] nxt_lin_wdog;
	logic [ATR_DATA_W-1:0] nxt_bg_iref;
	logic [ATR_SLP_STORED_W-1:0] nxt_sleep;
	logic [ATR_DATA_W-1:0] nxt_rdata;
	logic nxt_ack;
	logic nxt_nonblock;

	logic [15:0] rel_blocking;
	logic [15:0] rel_nonblock;
	logic in_blocking;
	logic in_nonblock;
	logic [7:0] offset;
	logic hit_lin_wdog;
	logic hit_bg_iref;
	logic hit_sleep;
	logic wr_sleep;
	logic held_en;
	logic held_lock;
	logic [ATR_CODE_W-1:0] held_code;
	logic [ATR_SLP_STORED_W-1:0] sleep_view;

	// Address decode against both global windows
	always_comb begin
		rel_blocking = bus_addr_i - ATR_BASE_BLOCKING;
		rel_nonblock = bus_addr_i - ATR_BASE_NONBLOCK;
		in_blocking = (bus_addr_i >= ATR_BASE_BLOCKING) && (rel_blocking < ATR_WINDOW_SPAN);
		in_nonblock = (bus_addr_i >= ATR_BASE_NONBLOCK) && (rel_nonblock < ATR_WINDOW_SPAN);
		offset = in_nonblock ? rel_nonblock[7:0] : rel_blocking[7:0];
		hit_lin_wdog = (in_blocking || in_nonblock) && (offset == ATR_OFS_LIN_WDOG);
		hit_bg_iref = (in_blocking || in_nonblock) && (offset == ATR_OFS_BG_IREF);
		hit_sleep = (in_blocking || in_nonblock) && (offset == ATR_OFS_SLEEP_REF);
		wr_sleep = bus_sel_i && bus_wr_i && hit_sleep && !held_lock;
	end

	// A locked register shows the held analog copy, not the cleared digital one
	always_comb begin
		if (held_lock) begin
			sleep_view = {held_en, held_lock, held_code};
		end else begin
			sleep_view = sleep_ff;
		end
	end

	// Register storage; no low-power input exists, so contents simply hold
	always_comb begin
		nxt_lin_wdog = lin_wdog_ff;
		nxt_bg_iref = bg_iref_ff;
		nxt_sleep = sleep_ff;
		if (bus_sel_i && bus_wr_i) begin
			if (hit_lin_wdog) begin
				nxt_lin_wdog = bus_wdata_i;
			end
			if (hit_bg_iref) begin
				nxt_bg_iref = bus_wdata_i;
			end
		end
		if (wr_sleep) begin
			nxt_sleep = bus_wdata_i[ATR_SLP_STORED_W-1:0];
			if (!bus_wdata_i[ATR_SLP_EN_BIT]) begin
				nxt_sleep[ATR_SLP_LOCK_BIT] = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lin_wdog_ff <= ATR_RST_LIN_WDOG;
			bg_iref_ff <= ATR_RST_BG_IREF;
			sleep_ff <= ATR_RST_SLEEP_REF;
		end else begin
			lin_wdog_ff <= nxt_lin_wdog;
			bg_iref_ff <= nxt_bg_iref;
			sleep_ff <= nxt_sleep;
		end
	end

	// Bus answer one cycle after each selected cycle; unmapped reads return zero
	always_comb begin
		nxt_ack = bus_sel_i;
		nxt_nonblock = bus_sel_i && in_nonblock;
		nxt_rdata = ATR_RDATA_NONE;
		if (bus_sel_i && !bus_wr_i) begin
			if (hit_lin_wdog) begin
				nxt_rdata = lin_wdog_ff;
			end else if (hit_bg_iref) begin
				nxt_rdata = bg_iref_ff;
			end else if (hit_sleep) begin
				nxt_rdata = {ATR_SLEEP_UPPER_ZERO, sleep_view};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			nonblock_ff <= 1'b0;
			rdata_ff <= ATR_RDATA_NONE;
		end else begin
			ack_ff <= nxt_ack;
			nonblock_ff <= nxt_nonblock;
			rdata_ff <= nxt_rdata;
		end
	end

	assign bus_ack_o = ack_ff;
	assign bus_nonblock_o = nonblock_ff;
	assign bus_rdata_o = rdata_ff;

	// Analog copy of the sleep reference trim; loads follow unlocked writes
	atr_sleep_hold u_sleep_hold (
		.core_clk_i(core_clk_i),
		.por_i(por_i),
		.rst_i(rst_i),
		.load_i(wr_sleep),
		.enable_i(bus_wdata_i[ATR_SLP_EN_BIT]),
		.lock_i(bus_wdata_i[ATR_SLP_LOCK_BIT]),
		.code_i(bus_wdata_i[ATR_SLP_CODE_LSB +: ATR_CODE_W]),
		.held_enable_o(held_en),
		.held_lock_o(held_lock),
		.held_code_o(held_code)
	);

	// Lock output mirrors the analog store; one cycle of registering keeps it a flop
	logic lock_out_ff;
	always_ff @(posedge core_clk_i) begin
		if (por_i) begin
			lock_out_ff <= 1'b0;
		end else begin
			lock_out_ff <= held_lock;
		end
	end
	assign sleep_ref_trim_lock_o = lock_out_ff;

	// Gated trim outputs; codes such as the doubly printed sleep 110 pass unchanged
	atr_trim_gate #(.W(1), .DEF_CODE(1'b0)) u_lin (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(lin_wdog_ff[ATR_LIN_EN_BIT]),
		.code_i(lin_wdog_ff[ATR_LIN_ADJ_BIT]),
		.trim_o(lin_slope_adjust_o)
	);

	atr_trim_gate #(.W(ATR_CODE_W), .DEF_CODE(ATR_CODE_UNTRIMMED)) u_wdog (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(lin_wdog_ff[ATR_WDOG_EN_BIT]),
		.code_i(lin_wdog_ff[ATR_WDOG_CODE_LSB +: ATR_CODE_W]),
		.trim_o(wdog_clock_trim_code_o)
	);

	atr_trim_gate #(.W(1), .DEF_CODE(1'b0)) u_bg_up (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(bg_iref_ff[ATR_BG_EN_BIT]),
		.code_i(bg_iref_ff[ATR_BG_UP_BIT]),
		.trim_o(bandgap_slope_up_o)
	);

	atr_trim_gate #(.W(1), .DEF_CODE(1'b0)) u_bg_dn (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(bg_iref_ff[ATR_BG_EN_BIT]),
		.code_i(bg_iref_ff[ATR_BG_DN_BIT]),
		.trim_o(bandgap_slope_down_o)
	);

	atr_trim_gate #(.W(ATR_CODE_W), .DEF_CODE(ATR_CODE_UNTRIMMED)) u_iref (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.en_i(bg_iref_ff[ATR_IREF_EN_BIT]),
		.code_i(bg_iref_ff[ATR_IREF_CODE_LSB +: ATR_CODE_W]),
		.trim_o(current_ref_trim_code_o)
	);

	// Sleep output is driven from the analog store so device reset cannot disturb it once locked
	atr_trim_gate #(.W(ATR_CODE_W), .DEF_CODE(ATR_CODE_UNTRIMMED)) u_sleep (
		.core_clk_i(core_clk_i),
		.rst_i(por_i),
		.en_i(held_en),
		.code_i(held_code),
		.trim_o(sleep_ref_trim_code_o)
	);
endmodule

// [src/atr_pkg.sv]
// Constants shared by the analog trim register bank
package atr_pkg;
	localparam int ATR_ADDR_W = 16;
	localparam int ATR_DATA_W = 8;
	localparam int ATR_CODE_W = 3;
	localparam logic [15:0] ATR_BASE_BLOCKING = 16'h0200;
	localparam logic [15:0] ATR_BASE_NONBLOCK = 16'h0300;
	localparam logic [15:0] ATR_WINDOW_SPAN = 16'h0100;
	localparam logic [7:0] ATR_OFS_LIN_WDOG = 8'hF0;
	localparam logic [7:0] ATR_OFS_BG_IREF = 8'hF1;
	localparam logic [7:0] ATR_OFS_SLEEP_REF = 8'hF2;
	localparam logic [7:0] ATR_RST_LIN_WDOG = 8'h00;
	localparam logic [7:0] ATR_RST_BG_IREF = 8'h00;
	localparam logic [4:0] ATR_RST_SLEEP_REF = 5'h00;
	localparam logic [7:0] ATR_RDATA_NONE = 8'h00;
	localparam logic [2:0] ATR_SLEEP_UPPER_ZERO = 3'h0;
	localparam logic [2:0] ATR_CODE_UNTRIMMED = 3'h0;
	// Field positions of the first trim register
	localparam int ATR_LIN_EN_BIT = 7;
	localparam int ATR_LIN_ADJ_BIT = 6;
	localparam int ATR_WDOG_EN_BIT = 5;
	localparam int ATR_WDOG_CODE_LSB = 0;
	// Field positions of the second trim register
	localparam int ATR_BG_EN_BIT = 7;
	localparam int ATR_BG_UP_BIT = 5;
	localparam int ATR_BG_DN_BIT = 4;
	localparam int ATR_IREF_EN_BIT = 3;
	localparam int ATR_IREF_CODE_LSB = 0;
	// Field positions of the third trim register
	localparam int ATR_SLP_EN_BIT = 4;
	localparam int ATR_SLP_LOCK_BIT = 3;
	localparam int ATR_SLP_CODE_LSB = 0;
	localparam int ATR_SLP_STORED_W = 5;
endpackage

// [src/atr_trim_gate.sv]
// Registered gate that passes a trim code only while its enable is set
`timescale 1ns/10ps
module atr_trim_gate #(
	parameter int W = 3,
	parameter logic [W-1:0] DEF_CODE = '0
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [W-1:0] code_i,
	output logic [W-1:0] trim_o
);
	logic [W-1:0] trim_ff;
	logic [W-1:0] nxt_trim;

	if (W < 1) begin : g_chk
		$error("atr_trim_gate: W must be at least 1");
	end

	always_comb begin
		nxt_trim = en_i ? code_i : DEF_CODE;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			trim_ff <= DEF_CODE;
		end else begin
			trim_ff <= nxt_trim;
		end
	end

	assign trim_o = trim_ff;
endmodule

// [src/atr_sleep_hold.sv]
// Sleep reference trim storage that only a power cycle clears once locked
`timescale 1ns/10ps
module atr_sleep_hold
	import atr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic por_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic enable_i,
	input wire logic lock_i,
	input wire logic [atr_pkg::ATR_CODE_W-1:0] code_i,
	output logic held_enable_o,
	output logic held_lock_o,
	output logic [atr_pkg::ATR_CODE_W-1:0] held_code_o
);
	logic en_ff;
	logic lock_ff;
	logic [ATR_CODE_W-1:0] code_ff;
	logic nxt_en;
	logic nxt_lock;
	logic [ATR_CODE_W-1:0] nxt_code;

	always_comb begin
		nxt_en = en_ff;
		nxt_lock = lock_ff;
		nxt_code = code_ff;
		if (!lock_ff) begin
			if (rst_i) begin
				nxt_en = 1'b0;
				nxt_lock = 1'b0;
				nxt_code = ATR_CODE_UNTRIMMED;
			end else if (load_i) begin
				nxt_en = enable_i;
				nxt_lock = lock_i & enable_i;
				nxt_code = code_i;
			end
		end
	end

	// Device reset is deliberately absent here; locked content outlives it
	always_ff @(posedge core_clk_i) begin
		if (por_i) begin
			en_ff <= 1'b0;
			lock_ff <= 1'b0;
			code_ff <= ATR_CODE_UNTRIMMED;
		end else begin
			en_ff <= nxt_en;
			lock_ff <= nxt_lock;
			code_ff <= nxt_code;
		end
	end

	assign held_enable_o = en_ff;
	assign held_lock_o = lock_ff;
	assign held_code_o = code_ff;
endmodule

// [tb/atr_mcu_model.sv]
// Controller-side model that issues register accesses to the trim bank
`timescale 1ns/10ps
module atr_mcu_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic ack_i,
	input wire logic nonblock_i,
	output logic sel_o,
	output logic wr_o,
	output logic [15:0] addr_o,
	output logic [7:0] wdata_o
);
	initial begin
		sel_o = 0;
		wr_o = 0;
		addr_o = 16'h0000;
		wdata_o = 8'h00;
	end
	// The bank takes every selected edge as a new access, so the strobe stands for one edge only;
	// address, direction and data stay until the answer is taken at the following edge
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic k, output logic nb);
		@(posedge core_clk_i);
		sel_o <= 1'b1;
		wr_o <= w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge core_clk_i);
		sel_o <= 1'b0;
		@(posedge core_clk_i);
		q = rdata_i;
		k = ack_i;
		nb = nonblock_i;
		wdata_o <= ~d;
	endtask
	// Startup copy keeps the lock masked so a default code is never frozen
	task automatic load(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		logic [7:0] q;
		logic k;
		logic nb;
		access(1, 16'h02F0, b0, q, k, nb);
		access(1, 16'h02F1, b1, q, k, nb);
		access(1, 16'h02F2, b2 & 8'hF7, q, k, nb);
	endtask
endmodule

// [tb/atr_trim_bank_asserts.sv]
// Port-level checker for the trim register bank
`timescale 1ns/10ps
module atr_trim_bank_asserts #(
	parameter int ADDR_W = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic bus_sel_i,
	input wire logic bus_wr_i,
	input wire logic [ADDR_W-1:0] bus_addr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic bus_ack_o,
	input wire logic bus_nonblock_o,
	input wire logic lin_slope_adjust_o,
	input wire logic [2:0] wdog_clock_trim_code_o,
	input wire logic bandgap_slope_up_o,
	input wire logic bandgap_slope_down_o,
	input wire logic [2:0] current_ref_trim_code_o,
	input wire logic [2:0] sleep_ref_trim_code_o,
	input wire logic sleep_ref_trim_lock_o
);
	logic [7:0] wd1_ff;
	logic [7:0] wd2_ff;
	logic win;
	logic nb_exp_ff;
	assign win = bus_addr_i[15:8] == 8'h02 || bus_addr_i[15:8] == 8'h03;
	always_ff @(posedge core_clk_i) begin
		wd1_ff <= bus_wdata_i;
		wd2_ff <= wd1_ff;
		nb_exp_ff <= bus_addr_i[15:8] == 8'h03;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i || por_i);
	sequence wr_f0; bus_sel_i && bus_wr_i && win && bus_addr_i[7:0] == 8'hF0; endsequence
	sequence wr_f1; bus_sel_i && bus_wr_i && win && bus_addr_i[7:0] == 8'hF1; endsequence
	sequence rd_f2; bus_sel_i && !bus_wr_i && win && bus_addr_i[7:0] == 8'hF2; endsequence
	ack_pulse_a: assert property (bus_sel_i |=> bus_ack_o) else $error("ack missing");
	ack_idle_a: assert property (!bus_sel_i |=> !bus_ack_o && bus_rdata_o == 8'h00) else $error("stray ack");
	nonblock_win_a: assert property (bus_sel_i |=> bus_nonblock_o == nb_exp_ff)
		else $error("window flag wrong");
	lin_out_a: assert property (wr_f0 |-> ##2 lin_slope_adjust_o == (wd2_ff[7] & wd2_ff[6]))
		else $error("lin slope output wrong");
	wdog_out_a: assert property (wr_f0 |-> ##2
		wdog_clock_trim_code_o == (wd2_ff[5] ? wd2_ff[2:0] : 3'h0)) else $error("watchdog code wrong");
	bg_out_a: assert property (wr_f1 |-> ##2 {bandgap_slope_up_o, bandgap_slope_down_o} ==
		(wd2_ff[7] ? wd2_ff[5:4] : 2'h0)) else $error("bandgap output wrong");
	iref_out_a: assert property (wr_f1 |-> ##2
		current_ref_trim_code_o == (wd2_ff[3] ? wd2_ff[2:0] : 3'h0)) else $error("reference code wrong");
	lock_hold_a: assert property (disable iff (por_i) sleep_ref_trim_lock_o |=> sleep_ref_trim_lock_o &&
		$stable(sleep_ref_trim_code_o)) else $error("locked trim changed");
	upper_zero_a: assert property (rd_f2 |=> bus_rdata_o[7:5] == 3'h0)
		else $error("upper bits not zero");
endmodule
bind atr_trim_bank atr_trim_bank_asserts #(.ADDR_W(ADDR_W)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.por_i(por_i), .bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i),
	.bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o),
	.bus_nonblock_o(bus_nonblock_o), .lin_slope_adjust_o(lin_slope_adjust_o),
	.wdog_clock_trim_code_o(wdog_clock_trim_code_o), .bandgap_slope_up_o(bandgap_slope_up_o),
	.bandgap_slope_down_o(bandgap_slope_down_o), .current_ref_trim_code_o(current_ref_trim_code_o),
	.sleep_ref_trim_code_o(sleep_ref_trim_code_o), .sleep_ref_trim_lock_o(sleep_ref_trim_lock_o));

// [tb/tb_atr_trim_bank.sv]
// Self-checking testbench for the trim register bank
`timescale 1ns/10ps
module tb_atr_trim_bank;
	import atr_pkg::*;
	logic clk = 0, rst = 1, por = 1, sel, wr, ack, nb, lin, bgu, bgd, lck;
	logic [15:0] addr;
	logic [7:0] wd, rd;
	logic [2:0] wdc, irc, slc;
	int err_count = 0, comparisons = 0;
	always #10 clk = ~clk;
	atr_trim_bank uut (.core_clk_i(clk), .rst_i(rst), .por_i(por), .bus_sel_i(sel), .bus_wr_i(wr),
		.bus_addr_i(addr), .bus_wdata_i(wd), .bus_rdata_o(rd), .bus_ack_o(ack), .bus_nonblock_o(nb),
		.lin_slope_adjust_o(lin), .wdog_clock_trim_code_o(wdc), .bandgap_slope_up_o(bgu),
		.bandgap_slope_down_o(bgd), .current_ref_trim_code_o(irc), .sleep_ref_trim_code_o(slc),
		.sleep_ref_trim_lock_o(lck));
	atr_mcu_model mcu (.core_clk_i(clk), .rdata_i(rd), .ack_i(ack), .nonblock_i(nb), .sel_o(sel),
		.wr_o(wr), .addr_o(addr), .wdata_o(wd));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
		logic [7:0] q;
		logic k, n;
		mcu.access(w, a, d, q, k, n);
		chk({6'h0, k, n}, {7'h01, a[8]});
		chk(q, w ? 8'h00 : e);
	endtask
	// Outputs lag a write by up to two cycles, so let three pass
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic p);
		@(posedge clk);
		rst <= 1;
		por <= p;
		repeat (2) @(posedge clk);
		rst <= 0;
		por <= 0;
	endtask
	task automatic t_load();
		acc(0, 16'h02F0, 0, 8'h00);
		acc(0, 16'h02F1, 0, 8'h00);
		acc(0, 16'h02F2, 0, 8'h00);
		mcu.load(8'hFF, 8'hFF, 8'h1F);
		acc(0, 16'h02F0, 0, 8'hFF);
		acc(0, 16'h03F1, 0, 8'hFF);
		acc(0, 16'h02F2, 0, 8'h17);
		acc(0, 16'h02F3, 0, 8'h00);
		$display("load test done");
	endtask
	task automatic t_lin();
		for (int i = 0; i < 8; i++) begin
			acc(1, 16'h02F0, 8'hE0 | i[7:0], 0);
			settle();
			chk({lin, wdc}, {1'b1, i[2:0]});
		end
		acc(1, 16'h03F0, 8'h47, 0);
		acc(0, 16'h02F0, 0, 8'h47);
		settle();
		chk({lin, wdc}, 8'h00);
		$display("lin and watchdog test done");
	endtask
	task automatic t_bg();
		for (int i = 0; i < 8; i++) begin
			acc(1, 16'h02F1, 8'hA8 | i[7:0], 0);
			settle();
			chk({bgu, bgd, irc}, {2'b10, i[2:0]});
		end
		acc(1, 16'h02F1, 8'h95, 0);
		settle();
		chk({bgu, bgd, irc}, 8'h08);
		acc(1, 16'h02F1, 8'h3D, 0);
		settle();
		chk({bgu, bgd, irc}, 8'h05);
		$display("bandgap and reference test done");
	endtask
	task automatic t_lock();
		acc(1, 16'h02F2, 8'hE5, 0);
		acc(0, 16'h02F2, 0, 8'h05);
		acc(1, 16'h02F2, 8'h0D, 0);
		acc(0, 16'h02F2, 0, 8'h05);
		settle();
		chk({lck, slc}, 8'h00);
		acc(1, 16'h02F2, 8'h1E, 0);
		settle();
		chk({lck, slc}, 8'h0E);
		acc(1, 16'h03F2, 8'h11, 0);
		acc(0, 16'h02F2, 0, 8'h1E);
		acc(1, 16'h02F0, 8'hFF, 0);
		pulse(0);
		acc(0, 16'h02F0, 0, 8'h00);
		acc(0, 16'h02F2, 0, 8'h1E);
		settle();
		chk({lck, slc}, 8'h0E);
		pulse(1);
		acc(0, 16'h02F2, 0, 8'h00);
		settle();
		chk({lck, slc}, 8'h00);
		$display("lock test done");
	endtask
	task automatic finish_test();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		por <= 0;
		t_load();
		t_lin();
		t_bg();
		t_lock();
		finish_test();
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule
